// ---- pkw_port.sv ----
// configurable port pin drivers with keypad wake-up interrupt
// Function
// - two mode bits per pin pick quasi, push-pull, input-only or open-drain driver
// - every configurable pin resets to quasi-bidirectional mode
// - quasi mode: very weak pull-up on whenever latch holds one
// - quasi mode: weak pull-up on only while latch and pin both read one
// - quasi mode: latch rising turns strong pull-up on for exactly two clocks
// - quasi mode: latch zero drives pin low through pull-down
// - open-drain: no pull-ups, pull-down only while latch holds zero
// - push-pull: strong pull-up while latch one, same pull-down while zero
// - port-one pins two and three are always open-drain whatever the mode bits
// - port-one pin five is Schmitt input only, enabled only with internal reset
// - crystal option disables input and output of both oscillator pins
// - after reset latches take the reset-level strap; high pins stay quasi
// - one Schmitt select bit per port; three fixed pins always Schmitt
// - spare port-two mode-a bits hold Schmitt, timer toggle and clock-out enables
// - one enable bit per port-zero pin for the keypad function
// - enabled port-zero pin low sets keypad flag and requests interrupt
// - keypad flag stays set until software writes zero to it
// - keypad event must wake the CPU from idle and power down; here KPD_WAKE is registered on CLK and needs CLK running
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module pkw_port
  import pkw_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire pkw_port_t PIN_IN,
  input wire logic CFG_RESET_HIGH,
  input wire logic CFG_INT_RESET,
  input wire logic CFG_XTAL,
  output pkw_drv_t PIN_DRV,
  output pkw_port_t PIN_IEN,
  output pkw_port_t PIN_SCHMITT,
  output logic T0_TOGGLE_EN,
  output logic T1_TOGGLE_EN,
  output logic CLOCK_OUTPUT_ENABLE,
  output logic IRQ,
  output logic KPD_WAKE
);
  typedef struct packed {
    logic init_done;
    pkw_port_t latch;
    pkw_port_t mode_a;
    pkw_port_t mode_b;
    logic [PKW_PORTS-1:0][PKW_W-1:0][1:0] spu_cnt;
    logic [7:0] kpd_en;
    logic kpd_flag;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [7:0] rdata;
    pkw_drv_t drv;
    pkw_port_t ien;
    pkw_port_t schm;
    logic irq;
    logic wake;
  } pkw_st_t;

  pkw_st_t st_r;
  pkw_st_t st_nxt;
  pkw_port_t pin_s;
  logic kpd_hit;

  // pin levels are asynchronous to CLK
  pkw_sync #(
    .W(PKW_PORTS * PKW_W)
  ) u_sync (
    .CLK(CLK),
    .NRST(NRST),
    .d(PIN_IN),
    .q(pin_s)
  );

  // mode of one pin after the fixed-function overrides
  function automatic logic [1:0] eff_mode(input pkw_st_t s, input int p, input int b);
    logic [1:0] m;
    m = {s.mode_a[p][b], s.mode_b[p][b]};
    if (p == PKW_PORT1 && (b == PKW_PIN_OD_A || b == PKW_PIN_OD_B)) begin
      m = PKW_MODE_OD;
    end else if (p == PKW_PORT1 && b == PKW_PIN_RST) begin
      m = PKW_MODE_INPUT;
    end
    return m;
  endfunction : eff_mode

  // whether a pin exists and has its paths enabled
  function automatic logic pin_live(input int p, input int b, input logic xtal,
                                    input logic int_rst);
    logic live;
    live = 1'b1;
    if (p == PKW_PORT2 && b >= PKW_P2_PINS) begin
      live = 1'b0;
    end else if (p == PKW_PORT2 && (b == PKW_PIN_OSC_OUT || b == PKW_PIN_OSC_IN)) begin
      live = ~xtal;
    end else if (p == PKW_PORT1 && b == PKW_PIN_RST) begin
      live = int_rst;
    end
    return live;
  endfunction : pin_live

  // any enabled keypad pin pulled low, seen through the synchroniser
  assign kpd_hit = |(st_r.kpd_en & ~pin_s[0]);

  // next state: register writes, strap load, pulse counters, keypad, outputs
  always_comb begin
    pkw_stage_t stg;
    logic live;
    stg = '0;
    live = 1'b0;
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    // register writes
    if (WR) begin
      case (ADDR)
        PKW_OFS_LATCH0: st_nxt.latch[0] = WDATA;
        PKW_OFS_LATCH1: st_nxt.latch[1] = WDATA;
        PKW_OFS_LATCH2: st_nxt.latch[2] = WDATA;
        PKW_OFS_MODEA0: st_nxt.mode_a[0] = WDATA;
        PKW_OFS_MODEA1: st_nxt.mode_a[1] = WDATA;
        PKW_OFS_MODEA2: st_nxt.mode_a[2] = WDATA;
        PKW_OFS_MODEB0: st_nxt.mode_b[0] = WDATA;
        PKW_OFS_MODEB1: st_nxt.mode_b[1] = WDATA;
        PKW_OFS_MODEB2: st_nxt.mode_b[2] = WDATA;
        PKW_OFS_KPD_EN: st_nxt.kpd_en = WDATA;
        PKW_OFS_AUX: begin
          if (!WDATA[PKW_AUX_KPD_FLAG]) begin
            st_nxt.kpd_flag = 1'b0;
          end
        end
        PKW_OFS_STAT: st_nxt.stat = st_r.stat & ~WDATA;
        PKW_OFS_MASK: st_nxt.mask = WDATA;
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
    // strap is caught on the first clock after reset release, not by the reset
    if (!st_r.init_done) begin
      st_nxt.init_done = 1'b1;
      st_nxt.latch = {(PKW_PORTS * PKW_W){CFG_RESET_HIGH}};
    end
    // set wins over a clear in the same cycle
    if (kpd_hit) begin
      st_nxt.kpd_flag = 1'b1;
      st_nxt.stat[PKW_STAT_KPD] = 1'b1;
    end
    // strong pull-up pulse per pin, restarted on every latch rise
    for (int p = 0; p < PKW_PORTS; p++) begin
      for (int b = 0; b < PKW_W; b++) begin
        if (!st_r.latch[p][b] && st_nxt.latch[p][b]) begin
          st_nxt.spu_cnt[p][b] = PKW_SPU_CYCLES;
        end else if (st_r.spu_cnt[p][b] != 2'h0) begin
          st_nxt.spu_cnt[p][b] = st_r.spu_cnt[p][b] - 2'h1;
        end
      end
    end
    // pin outputs follow the next latch and mode so they line up with the registers
    for (int p = 0; p < PKW_PORTS; p++) begin
      for (int b = 0; b < PKW_W; b++) begin
        live = pin_live(p, b, CFG_XTAL, CFG_INT_RESET);
        stg = pkw_pin_drive(eff_mode(st_nxt, p, b), st_nxt.latch[p][b],
                            st_nxt.spu_cnt[p][b] != 2'h0, pin_s[p][b]);
        if (!live) begin
          stg = '0;
        end
        st_nxt.drv.pd[p][b] = stg.pd;
        st_nxt.drv.spu[p][b] = stg.spu;
        st_nxt.drv.wpu[p][b] = stg.wpu;
        st_nxt.drv.vwpu[p][b] = stg.vwpu;
        st_nxt.ien[p][b] = live;
        st_nxt.schm[p][b] = st_nxt.mode_a[PKW_PORT2][PKW_P2MA_SCHMITT_LSB + p];
        if (p == PKW_PORT1 && (b == PKW_PIN_OD_A || b == PKW_PIN_OD_B || b == PKW_PIN_RST)) begin
          st_nxt.schm[p][b] = 1'b1;
        end
      end
    end
    // level interrupt and wake request; the wake flop needs CLK running
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    st_nxt.wake = st_nxt.kpd_flag & st_nxt.mask[PKW_STAT_KPD];
    // read data stand in the cycle after the strobe only
    if (RD) begin
      case (ADDR)
        PKW_OFS_LATCH0: st_nxt.rdata = st_r.latch[0];
        PKW_OFS_LATCH1: st_nxt.rdata = st_r.latch[1];
        PKW_OFS_LATCH2: st_nxt.rdata = st_r.latch[2];
        PKW_OFS_MODEA0: st_nxt.rdata = st_r.mode_a[0];
        PKW_OFS_MODEA1: st_nxt.rdata = st_r.mode_a[1];
        PKW_OFS_MODEA2: st_nxt.rdata = st_r.mode_a[2];
        PKW_OFS_MODEB0: st_nxt.rdata = st_r.mode_b[0];
        PKW_OFS_MODEB1: st_nxt.rdata = st_r.mode_b[1];
        PKW_OFS_MODEB2: st_nxt.rdata = st_r.mode_b[2];
        PKW_OFS_KPD_EN: st_nxt.rdata = st_r.kpd_en;
        PKW_OFS_AUX: st_nxt.rdata = 8'(st_r.kpd_flag) << PKW_AUX_KPD_FLAG;
        PKW_OFS_STAT: st_nxt.rdata = st_r.stat;
        PKW_OFS_MASK: st_nxt.rdata = st_r.mask;
        PKW_OFS_PIN0: st_nxt.rdata = pin_s[0] & st_r.ien[0];
        PKW_OFS_PIN1: st_nxt.rdata = pin_s[1] & st_r.ien[1];
        PKW_OFS_PIN2: st_nxt.rdata = pin_s[2] & st_r.ien[2];
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register; modes reset to quasi, latches low until the strap load
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
      st_r.mode_a <= {PKW_PORTS{PKW_RST_MODE}};
      st_r.mode_b <= {PKW_PORTS{PKW_RST_MODE}};
      st_r.kpd_en <= PKW_RST_KPD_EN;
      st_r.mask <= PKW_RST_MASK;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata;
  assign PIN_DRV = st_r.drv;
  assign PIN_IEN = st_r.ien;
  assign PIN_SCHMITT = st_r.schm;
  assign T0_TOGGLE_EN = st_r.mode_a[PKW_PORT2][PKW_P2MA_T0_TOG];
  assign T1_TOGGLE_EN = st_r.mode_a[PKW_PORT2][PKW_P2MA_T1_TOG];
  assign CLOCK_OUTPUT_ENABLE = st_r.mode_a[PKW_PORT2][PKW_P2MA_CLKOUT];
  assign IRQ = st_r.irq;
  assign KPD_WAKE = st_r.wake;

  // strong pull-up on port-zero pin zero lasts two cycles after a quasi latch rise
  property p_spu_pulse;
    @(posedge CLK) disable iff (!NRST)
      ($rose(st_r.latch[0][0]) && st_r.mode_a[0][0] == 1'b0 && st_r.mode_b[0][0] == 1'b0)
        |-> PIN_DRV.spu[0][0] ##1 (PIN_DRV.spu[0][0] || !st_r.latch[0][0]);
  endproperty
  a_spu_pulse: assert property (p_spu_pulse) else $error("strong pull-up pulse too short");

  property p_spu_end;
    @(posedge CLK) disable iff (!NRST)
      ($rose(st_r.latch[0][0]) && {st_r.mode_a[0][0], st_r.mode_b[0][0]} == PKW_MODE_QUASI)
        ##1 (st_r.latch[0][0] && $stable({st_r.mode_a[0][0], st_r.mode_b[0][0]}))
        ##1 (st_r.latch[0][0] && $stable({st_r.mode_a[0][0], st_r.mode_b[0][0]}))
        |-> !PIN_DRV.spu[0][0];
  endproperty
  a_spu_end: assert property (p_spu_end) else $error("strong pull-up pulse too long");

  // outputs still hold their reset zeros at the first edge after release, hence the past check
  property p_vwpu;
    @(posedge CLK) disable iff (!NRST)
      ($past(NRST) && {st_r.mode_a[0][1], st_r.mode_b[0][1]} == PKW_MODE_QUASI)
        |-> (PIN_DRV.vwpu[0][1] == st_r.latch[0][1] && PIN_DRV.pd[0][1] == !st_r.latch[0][1]);
  endproperty
  a_vwpu: assert property (p_vwpu) else $error("quasi very weak pull-up or pull-down wrong");

  // weak pull-up is registered from the synchronised level seen one edge earlier
  property p_wpu_off;
    @(posedge CLK) disable iff (!NRST)
      ({st_r.mode_a[0][2], st_r.mode_b[0][2]} == PKW_MODE_QUASI)
        |-> (PIN_DRV.wpu[0][2] == (st_r.latch[0][2] && $past(pin_s[0][2])));
  endproperty
  a_wpu_off: assert property (p_wpu_off) else $error("weak pull-up on with pin low");

  property p_od;
    @(posedge CLK) disable iff (!NRST)
      ({st_r.mode_a[0][3], st_r.mode_b[0][3]} == PKW_MODE_OD)
        |-> (!PIN_DRV.spu[0][3] && !PIN_DRV.wpu[0][3] && !PIN_DRV.vwpu[0][3]
             && PIN_DRV.pd[0][3] == !st_r.latch[0][3]);
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin has a pull-up");

  property p_push;
    @(posedge CLK) disable iff (!NRST)
      ({st_r.mode_a[0][4], st_r.mode_b[0][4]} == PKW_MODE_PUSH)
        |-> (PIN_DRV.spu[0][4] == st_r.latch[0][4] && PIN_DRV.pd[0][4] == !st_r.latch[0][4]);
  endproperty
  a_push: assert property (p_push) else $error("push-pull drive wrong");

  property p_fixed_od;
    @(posedge CLK) disable iff (!NRST)
      $past(NRST) |-> (PIN_DRV.spu[PKW_PORT1][PKW_PIN_OD_A] == 1'b0
                && PIN_DRV.wpu[PKW_PORT1][PKW_PIN_OD_B] == 1'b0
                && PIN_DRV.pd[PKW_PORT1][PKW_PIN_OD_A] == !st_r.latch[PKW_PORT1][PKW_PIN_OD_A]
                && PIN_DRV.pd[PKW_PORT1][PKW_PIN_RST] == 1'b0);
  endproperty
  a_fixed_od: assert property (p_fixed_od) else $error("fixed pin driven wrongly");

  property p_xtal;
    @(posedge CLK) disable iff (!NRST)
      (CFG_XTAL && $past(CFG_XTAL)) |-> (PIN_IEN[PKW_PORT2][1:0] == 2'h0
                                         && PIN_DRV.pd[PKW_PORT2][1:0] == 2'h0);
  endproperty
  a_xtal: assert property (p_xtal) else $error("oscillator pins not disabled");

  property p_kpd_set;
    @(posedge CLK) disable iff (!NRST)
      (kpd_hit) |=> (st_r.kpd_flag && st_r.stat[PKW_STAT_KPD]) ##1 IRQ == st_r.mask[PKW_STAT_KPD];
  endproperty
  a_kpd_set: assert property (p_kpd_set) else $error("keypad hit did not set flag");

  property p_kpd_hold;
    @(posedge CLK) disable iff (!NRST)
      (st_r.kpd_flag && !(WR && ADDR == PKW_OFS_AUX && !WDATA[PKW_AUX_KPD_FLAG]))
        |=> st_r.kpd_flag;
  endproperty
  a_kpd_hold: assert property (p_kpd_hold) else $error("keypad flag cleared by hardware");

  property p_strap;
    @(posedge CLK) disable iff (!NRST)
      (!st_r.init_done) |=> (st_r.latch == {(PKW_PORTS * PKW_W){$past(CFG_RESET_HIGH)}});
  endproperty
  a_strap: assert property (p_strap) else $error("latches not loaded from reset strap");

  // the request line is a plain function of the sticky status and its mask
  property p_irq_level;
    @(posedge CLK) disable iff (!NRST)
      1'b1 |-> (IRQ == |(st_r.stat & st_r.mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  // wake request follows the keypad flag while its mask bit is set
  property p_wake;
    @(posedge CLK) disable iff (!NRST)
      1'b1 |-> (KPD_WAKE == (st_r.kpd_flag && st_r.mask[PKW_STAT_KPD]));
  endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong");

  // the three fixed pins keep Schmitt inputs whatever the port select says
  property p_fixed_schmitt;
    @(posedge CLK) disable iff (!NRST)
      $past(NRST) |-> (PIN_SCHMITT[PKW_PORT1][PKW_PIN_OD_A]
                       && PIN_SCHMITT[PKW_PORT1][PKW_PIN_OD_B]
                       && PIN_SCHMITT[PKW_PORT1][PKW_PIN_RST]);
  endproperty
  a_fixed_schmitt: assert property (p_fixed_schmitt) else $error("fixed pin not Schmitt");

  // with the external reset in use the shared pin has no input path and no drive
  property p_rst_pin;
    @(posedge CLK) disable iff (!NRST)
      (!CFG_INT_RESET && !$past(CFG_INT_RESET))
        |-> (!PIN_IEN[PKW_PORT1][PKW_PIN_RST] && !PIN_DRV.pd[PKW_PORT1][PKW_PIN_RST]);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin input not disabled");

  // a pin left out of the keypad enable can never raise the flag
  property p_kpd_quiet;
    @(posedge CLK) disable iff (!NRST)
      (!st_r.kpd_flag && (st_r.kpd_en & ~pin_s[0]) == 8'h00) |=> !st_r.kpd_flag;
  endproperty
  a_kpd_quiet: assert property (p_kpd_quiet) else $error("keypad flag set without hit");
endmodule : pkw_port

// ---- pkw_pkg.sv ----
// shared constants, carrier types and the pin synchroniser of the configurable port block
`timescale 1ns/1ps
package pkw_pkg;
  localparam int PKW_PORTS = 3;
  localparam int PKW_W = 8;
  typedef logic [PKW_PORTS-1:0][PKW_W-1:0] pkw_port_t;
  // pull stages of every pin, one bit per pin per stage
  typedef struct packed {
    pkw_port_t pd;
    pkw_port_t spu;
    pkw_port_t wpu;
    pkw_port_t vwpu;
  } pkw_drv_t;
  typedef struct packed {
    logic pd;
    logic spu;
    logic wpu;
    logic vwpu;
  } pkw_stage_t;
  // driver mode as {pin_mode_bit_a, pin_mode_bit_b}
  localparam logic [1:0] PKW_MODE_QUASI = 2'h0;
  localparam logic [1:0] PKW_MODE_PUSH = 2'h1;
  localparam logic [1:0] PKW_MODE_INPUT = 2'h2;
  localparam logic [1:0] PKW_MODE_OD = 2'h3;
  // register offsets on the plain register port
  localparam logic [3:0] PKW_OFS_LATCH0 = 4'h0;
  localparam logic [3:0] PKW_OFS_LATCH1 = 4'h1;
  localparam logic [3:0] PKW_OFS_LATCH2 = 4'h2;
  localparam logic [3:0] PKW_OFS_MODEA0 = 4'h3;
  localparam logic [3:0] PKW_OFS_MODEA1 = 4'h4;
  localparam logic [3:0] PKW_OFS_MODEA2 = 4'h5;
  localparam logic [3:0] PKW_OFS_MODEB0 = 4'h6;
  localparam logic [3:0] PKW_OFS_MODEB1 = 4'h7;
  localparam logic [3:0] PKW_OFS_MODEB2 = 4'h8;
  localparam logic [3:0] PKW_OFS_KPD_EN = 4'h9;
  localparam logic [3:0] PKW_OFS_AUX = 4'ha;
  localparam logic [3:0] PKW_OFS_STAT = 4'hb;
  localparam logic [3:0] PKW_OFS_MASK = 4'hc;
  localparam logic [3:0] PKW_OFS_PIN0 = 4'hd;
  localparam logic [3:0] PKW_OFS_PIN1 = 4'he;
  localparam logic [3:0] PKW_OFS_PIN2 = 4'hf;
  // field positions
  localparam int PKW_P2MA_SCHMITT_LSB = 2;
  localparam int PKW_P2MA_T0_TOG = 5;
  localparam int PKW_P2MA_T1_TOG = 6;
  localparam int PKW_P2MA_CLKOUT = 7;
  localparam int PKW_AUX_KPD_FLAG = 1;
  localparam int PKW_STAT_KPD = 0;
  // special pins
  localparam int PKW_PORT1 = 1;
  localparam int PKW_PORT2 = 2;
  localparam int PKW_PIN_OD_A = 2;
  localparam int PKW_PIN_OD_B = 3;
  localparam int PKW_PIN_RST = 5;
  localparam int PKW_PIN_OSC_OUT = 0;
  localparam int PKW_PIN_OSC_IN = 1;
  localparam int PKW_P2_PINS = 2;
  // reset values and timing
  localparam logic [7:0] PKW_RST_MODE = 8'h00;
  localparam logic [7:0] PKW_RST_KPD_EN = 8'h00;
  localparam logic [7:0] PKW_RST_MASK = 8'h00;
  localparam int PKW_SPU_CPU_CLOCKS = 2;
  localparam logic [1:0] PKW_SPU_CYCLES = 2'(PKW_SPU_CPU_CLOCKS);

  // pull stages of one pin from its mode, latch, strong-pulse state and pin level
  function automatic pkw_stage_t pkw_pin_drive(input logic [1:0] mode, input logic latch,
                                               input logic pulse, input logic pin_hi);
    pkw_stage_t s;
    s = '0;
    case (mode)
      PKW_MODE_QUASI: begin
        s.vwpu = latch;
        s.wpu = latch & pin_hi;
        s.spu = latch & pulse;
        s.pd = ~latch;
      end
      PKW_MODE_PUSH: begin
        s.spu = latch;
        s.pd = ~latch;
      end
      PKW_MODE_OD: begin
        s.pd = ~latch;
      end
      default: begin
        s = '0;
      end
    endcase
    return s;
  endfunction : pkw_pin_drive
endpackage : pkw_pkg

// two-flop synchroniser for the pin levels
module pkw_sync
  import pkw_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pkw_sync_st_t;
  pkw_sync_st_t st_r;
  pkw_sync_st_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : pkw_sync

// ---- pkw_pin_model.sv ----
// pin-side model: external circuits and keypad switches on the port pins
`timescale 1ns/1ps
module pkw_pin_model
  import pkw_pkg::*;
(
  input wire logic CLK,
  input wire pkw_drv_t PIN_DRV,
  input wire pkw_port_t KEY_LOW,
  output pkw_port_t PIN_LEVEL
);
  // known start so a floating pin toggles instead of staying unknown
  pkw_port_t last_r = '0;

  // a closed key beats any pull-up; an undriven pin inverts each cycle so nothing settles by luck
  always_comb begin
    for (int p = 0; p < PKW_PORTS; p++) begin
      for (int b = 0; b < PKW_W; b++) begin
        if (PIN_DRV.pd[p][b] || KEY_LOW[p][b]) begin
          PIN_LEVEL[p][b] = 1'b0;
        end else if (PIN_DRV.spu[p][b] || PIN_DRV.wpu[p][b] || PIN_DRV.vwpu[p][b]) begin
          PIN_LEVEL[p][b] = 1'b1;
        end else begin
          PIN_LEVEL[p][b] = ~last_r[p][b];
        end
      end
    end
  end

  // last level seen, for the floating case
  always_ff @(posedge CLK) begin
    last_r <= PIN_LEVEL;
  end
endmodule : pkw_pin_model

// ---- tb_port_config_keypad_wake.sv ----
// self-checking bench of the configurable port block
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_port_config_keypad_wake import pkw_pkg::*;;
  logic clk, nrst, wr, rd, cfg_hi, cfg_int, cfg_xtal, t0, t1, ck, irq, wake;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  pkw_port_t pin_in, key_low, pin_ien, pin_sch;
  pkw_drv_t drv;
  int n_fail, comparisons;

  always #2.5 clk = ~clk;

  pkw_port u_dut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PIN_IN(pin_in), .CFG_RESET_HIGH(cfg_hi), .CFG_INT_RESET(cfg_int),
    .CFG_XTAL(cfg_xtal), .PIN_DRV(drv), .PIN_IEN(pin_ien), .PIN_SCHMITT(pin_sch),
    .T0_TOGGLE_EN(t0), .T1_TOGGLE_EN(t1), .CLOCK_OUTPUT_ENABLE(ck), .IRQ(irq),
    .KPD_WAKE(wake));
  pkw_pin_model u_pins (.CLK(clk), .PIN_DRV(drv), .KEY_LOW(key_low), .PIN_LEVEL(pin_in));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // settle after n edges, so registered outputs are sampled after they land
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : chk_reg

  task automatic do_reset(input logic hi);
    @(posedge clk);
    nrst <= 1'b0;
    cfg_hi <= hi;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tick(2);
  endtask : do_reset

  task automatic t_reset();
    do_reset(1'b0);
    `CHK(drv.pd[0], 8'hff)
    chk_reg(PKW_OFS_LATCH2, 8'h00);
    do_reset(1'b1);
    chk_reg(PKW_OFS_LATCH0, 8'hff);
    chk_reg(PKW_OFS_MODEA0, 8'h00);
    chk_reg(PKW_OFS_MODEB1, 8'h00);
    `CHK(drv.vwpu[0], 8'hff)
    chk_reg(PKW_OFS_PIN0, 8'hff);
  endtask : t_reset

  task automatic t_pulse();
    wr_reg(PKW_OFS_LATCH0, 8'h00);
    `CHK(drv.pd[0], 8'hff)
    tick(4);
    wr_reg(PKW_OFS_LATCH0, 8'hff);
    `CHK(drv.spu[0], 8'hff)
    tick(1);
    `CHK(drv.spu[0], 8'hff)
    tick(1);
    `CHK(drv.spu[0], 8'h00)
  endtask : t_pulse

  // every mode on port one; pins 2,3 stay open drain and pin 5 input whatever is written
  task automatic t_modes();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr_reg(PKW_OFS_MODEA1, {8{m[1]}});
      wr_reg(PKW_OFS_MODEB1, {8{m[0]}});
      wr_reg(PKW_OFS_LATCH1, 8'h00);
      `CHK(drv.pd[1], (m == 2'h2) ? 8'h0c : 8'hdf)
      `CHK(drv.spu[1] | drv.vwpu[1], 8'h00)
      wr_reg(PKW_OFS_LATCH1, 8'hff);
      tick(6);
      `CHK(drv.spu[1], (m == 2'h1) ? 8'hd3 : 8'h00)
      `CHK(drv.vwpu[1], (m == 2'h0) ? 8'hd3 : 8'h00)
      `CHK(drv.wpu[1], (m == 2'h0) ? 8'hd3 : 8'h00)
      `CHK(drv.pd[1], 8'h00)
    end
    wr_reg(PKW_OFS_MODEA1, 8'h00);
    wr_reg(PKW_OFS_MODEB1, 8'h00);
  endtask : t_modes

  task automatic press(input int b, input logic v);
    @(posedge clk);
    key_low[0][b] <= v;
  endtask : press

  task automatic t_keypad();
    int k;
    wr_reg(PKW_OFS_KPD_EN, 8'h01);
    wr_reg(PKW_OFS_MASK, 8'h01);
    press(1, 1'b1);
    tick(8);
    `CHK(irq, 1'b0)
    chk_reg(PKW_OFS_STAT, 8'h00);
    press(1, 1'b0);
    press(0, 1'b1);
    k = 0;
    while (irq !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    if (k == 20) begin
      n_fail++;
      $display("Error at %0t: no interrupt after key press", $time);
      conclude();
    end
    `CHK(wake, 1'b1)
    tick(3);
    `CHK({drv.wpu[0][0], drv.vwpu[0][0]}, 2'h1)
    chk_reg(PKW_OFS_AUX, 8'h02);
    press(0, 1'b0);
    tick(5);
    chk_reg(PKW_OFS_STAT, 8'h01);
    wr_reg(PKW_OFS_STAT, 8'h01);
    tick(2);
    `CHK(irq, 1'b0)
    chk_reg(PKW_OFS_AUX, 8'h02);
    wr_reg(PKW_OFS_AUX, 8'h00);
    tick(2);
    chk_reg(PKW_OFS_AUX, 8'h00);
    `CHK(wake, 1'b0)
    // masked: the flag still sets but no request goes out
    wr_reg(PKW_OFS_MASK, 8'h00);
    press(0, 1'b1);
    tick(8);
    `CHK(irq, 1'b0)
    chk_reg(PKW_OFS_STAT, 8'h01);
    press(0, 1'b0);
    tick(3);
    wr_reg(PKW_OFS_STAT, 8'h01);
    wr_reg(PKW_OFS_AUX, 8'h00);
    chk_reg(PKW_OFS_STAT, 8'h00);
  endtask : t_keypad

  task automatic t_misc();
    @(posedge clk);
    cfg_xtal <= 1'b1;
    cfg_int <= 1'b0;
    tick(3);
    `CHK(pin_ien[2], 8'h00)
    `CHK(pin_ien[1][5], 1'b0)
    @(posedge clk);
    cfg_xtal <= 1'b0;
    cfg_int <= 1'b1;
    tick(3);
    `CHK(pin_ien[2], 8'h03)
    `CHK(pin_ien[1][5], 1'b1)
    wr_reg(PKW_OFS_MODEA2, 8'he4);
    `CHK(pin_sch[0], 8'hff)
    `CHK(pin_sch[1], 8'h2c)
    `CHK({ck, t1, t0}, 3'h7)
    wr_reg(PKW_OFS_MODEA2, 8'h18);
    `CHK(pin_sch[0], 8'h00)
    `CHK({ck, t1, t0}, 3'h0)
    chk_reg(PKW_OFS_MODEA2, 8'h18);
    wr_reg(PKW_OFS_PIN0, 8'h00);
    tick(3);
    chk_reg(PKW_OFS_PIN0, 8'hff);
  endtask : t_misc

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    cfg_hi = 1'b1;
    cfg_int = 1'b1;
    cfg_xtal = 1'b0;
    key_low = '0;
    n_fail = 0;
    comparisons = 0;
    t_reset();
    t_pulse();
    t_modes();
    t_keypad();
    t_misc();
    conclude();
  end
endmodule : tb_port_config_keypad_wake
